// [shared/ext_irq_map.svh]
// register offsets, field positions, reset values and vector addresses
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH
`define ADDR_MCU_CTRL      12'h035
`define ADDR_IRQ_ENABLE    12'h03b
`define ADDR_IRQ_FLAGS     12'h03a
`define ADDR_PC_MASK_LOW   12'h012
`define ADDR_PC_MASK_HIGH  12'h020
`define ADDR_CORE_CTRL     12'h040
`define ADDR_CORE_STATUS   12'h044
`define BIT_EXT            6
`define BIT_PC_HIGH        5
`define BIT_PC_LOW         4
`define RST_MCU_CTRL       8'h00
`define RST_PC_MASK        8'h00
`define VEC_RESET          5'h00
`define VEC_EXT            5'h01
`define VEC_PC_LOW         5'h02
`define VEC_PC_HIGH        5'h03
`define VEC_WATCHDOG       5'h04
`define VEC_LAST           5'h10
`define NUM_SRC            17
`endif

// [shared/ext_irq_pkg.sv]
// types for the external interrupt and vectoring block
package ext_irq_pkg;
   typedef enum logic [1:0] {
      SENSE_LOW,
      SENSE_ANY,
      SENSE_FALL,
      SENSE_RISE
   } sense_e;
   typedef struct packed {
      logic        take;
      logic [4:0]  vector;
   } vec_req_s;
   typedef enum {
      VEC_IDLE,
      VEC_ACK
   } vec_state_e;
endpackage

// [hw/external_interrupt_vectoring.sv]
// external interrupt sensing, pin change groups and fixed vectoring
//
// How it works
// R1: reset fetch address zero, vectors numbered after
// R2: ext 0x1, low group 0x2, high 0x3
// R3: watchdog 0x4, 16-bit timer 0x5..0x8
// R4: 8-bit timer 0x9..0xB, others 0xC..0x10
// R5: pins trigger even when driven as outputs
// R6: low group flags any enabled 7..0 toggle
// R7: high group flags any enabled 11..8 toggle
// R8: mask registers select contributing pin inputs
// R9: pin changes seen without io clock
// R10: sense bits pick fall, rise or level
// R11: level request holds while pin low
// R12: edges need io clock, not in sleep
// R13: low level detected without io clock
// R14: wake without interrupt if level released early
// R15: sense code 00 low,01 any,10 fall,11 rise
// R16: take needs own enable and global enable
// R17: flag set on edge, cleared by ack/write
// R18: pin sampled; pulses over one clock caught
// R19: lowest pending vector number served first
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_map.svh"
module external_interrupt_vectoring #(
   parameter int PIN_CHANGE_COUNT = 12
) (
   input  wire logic                        mclk,
   input  wire logic                        sys_rst,
   input  wire logic [11:0]                 paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        ext_irq_pin,
   input  wire logic [PIN_CHANGE_COUNT-1:0] pin_change_inputs,
   input  wire logic                        ioClkRun,
   input  wire logic [12:0]                 otherIrq,
   input  wire logic                        vecAck,
   output ext_irq_pkg::vec_req_s            vecReq,
   output logic                             wakeReq
);
   logic        extSync1_q, extSync2_q, extPrev_q;
   logic [11:0] pcSync1_q, pcSync2_q, pcPrev_q;
   logic [7:0]  mcuCtrl_q, maskLow_q;
   logic [3:0]  maskHigh_q;
   logic [2:0]  enable_q;
   logic        globalEn_q;
   logic        extFlag_q, pcLowFlag_q, pcHighFlag_q;
   logic        apbWr, mapped;
   logic        extEvent, pcLowEvent, pcHighEvent, levelAct;
   logic [31:0] rdMux;
   logic [`NUM_SRC:1] pending;
   logic [4:0]  ackVec_q;
   ext_irq_pkg::sense_e sense;
   ext_irq_pkg::vec_req_s req_d;
   ext_irq_pkg::vec_state_e state_q;

   // every check below runs on mclk and sleeps through reset
   default clocking chkClk @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   // scan from the top so the lowest set index is the one left
   function automatic logic [4:0] lowestVec(input logic [`NUM_SRC:1] p);
      logic [4:0] v;
      v = 5'h00;
      for (int i = `NUM_SRC; i >= 1; i--) begin
         if (p[i]) begin
            v = 5'(i);
         end
      end
      return v;
   endfunction

   // two-flop samplers; pins read directly so outputs-as-inputs work
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         extSync1_q <= 1'b1;
         extSync2_q <= 1'b1;
         pcSync1_q  <= 12'h000;
         pcSync2_q  <= 12'h000;
      end else begin
         extSync1_q <= ext_irq_pin; // R5 R18
         extSync2_q <= extSync1_q;
         pcSync1_q  <= pin_change_inputs[11:0]; // R5
         pcSync2_q  <= pcSync1_q;
      end
   end

   // ext edge history only advances while io clock runs; pin change history advances every clock
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         extPrev_q <= 1'b1;
         pcPrev_q  <= 12'h000;
      end else begin
         if (ioClkRun) begin
            extPrev_q <= extSync2_q; // R12
         end
         pcPrev_q <= pcSync2_q; // R9
      end
   end

   assign sense = ext_irq_pkg::sense_e'(mcuCtrl_q[1:0]); // R15
   always_comb begin
      extEvent = 1'b0;
      unique case (sense) // R10
         ext_irq_pkg::SENSE_LOW:  extEvent = 1'b0;
         ext_irq_pkg::SENSE_ANY:  extEvent = extSync2_q ^ extPrev_q;
         ext_irq_pkg::SENSE_FALL: extEvent = extPrev_q & ~extSync2_q;
         ext_irq_pkg::SENSE_RISE: extEvent = ~extPrev_q & extSync2_q;
      endcase
      extEvent = extEvent & ioClkRun; // R12
   end
   // level path bypasses io clock gating
   assign levelAct = (sense == ext_irq_pkg::SENSE_LOW) & ~extSync2_q; // R11 R13
   assign pcLowEvent  = |((pcSync2_q[7:0] ^ pcPrev_q[7:0]) & maskLow_q); // R6 R8
   assign pcHighEvent = |((pcSync2_q[11:8] ^ pcPrev_q[11:8]) & maskHigh_q); // R7 R8

   // apb: zero wait states, unmapped reads zero with error
   assign apbWr = psel & penable & pwrite;
   assign pready = 1'b1;
   always_comb begin
      mapped = 1'b1;
      rdMux  = 32'h0000_0000;
      unique case (paddr)
         `ADDR_MCU_CTRL:     rdMux[7:0] = {6'h00, mcuCtrl_q[1:0]};
         `ADDR_IRQ_ENABLE:   rdMux[7:4] = {1'b0, enable_q};
         `ADDR_IRQ_FLAGS:    rdMux[7:4] = {1'b0, extFlag_q, pcHighFlag_q,
                                           pcLowFlag_q};
         `ADDR_PC_MASK_LOW:  rdMux[7:0] = maskLow_q;
         `ADDR_PC_MASK_HIGH: rdMux[3:0] = maskHigh_q;
         `ADDR_CORE_CTRL:    rdMux[0]   = globalEn_q;
         `ADDR_CORE_STATUS:  rdMux[5:0] = {vecReq.take, vecReq.vector};
         default:            mapped = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~mapped;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rdMux;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mcuCtrl_q  <= `RST_MCU_CTRL; // R15
         maskLow_q  <= `RST_PC_MASK;
         maskHigh_q <= 4'h0;
         enable_q   <= 3'h0;
         globalEn_q <= 1'b0;
      end else if (apbWr) begin
         unique case (paddr)
            `ADDR_MCU_CTRL:     mcuCtrl_q  <= {6'h00, pwdata[1:0]};
            `ADDR_IRQ_ENABLE:   enable_q   <= pwdata[6:4];
            `ADDR_PC_MASK_LOW:  maskLow_q  <= pwdata[7:0];
            `ADDR_PC_MASK_HIGH: maskHigh_q <= pwdata[3:0];
            `ADDR_CORE_CTRL:    globalEn_q <= pwdata[0];
            default:            ;
         endcase
      end
   end

   logic wrFlags, ackExt, ackLow, ackHigh;
   assign wrFlags = apbWr & (paddr == `ADDR_IRQ_FLAGS);
   assign ackExt  = vecAck & (ackVec_q == `VEC_EXT);
   assign ackLow  = vecAck & (ackVec_q == `VEC_PC_LOW);
   assign ackHigh = vecAck & (ackVec_q == `VEC_PC_HIGH);

   // set beats clear so no event is lost
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         extFlag_q <= 1'b0;
      end else if (sense == ext_irq_pkg::SENSE_LOW) begin
         extFlag_q <= 1'b0; // R17
      end else if (extEvent) begin
         extFlag_q <= 1'b1; // R17
      end else if (ackExt | (wrFlags & pwdata[`BIT_EXT])) begin
         extFlag_q <= 1'b0; // R17
      end
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pcLowFlag_q  <= 1'b0;
         pcHighFlag_q <= 1'b0;
      end else begin
         if (pcLowEvent) begin
            pcLowFlag_q <= 1'b1; // R6
         end else if (ackLow | (wrFlags & pwdata[`BIT_PC_LOW])) begin
            pcLowFlag_q <= 1'b0;
         end
         if (pcHighEvent) begin
            pcHighFlag_q <= 1'b1; // R7
         end else if (ackHigh | (wrFlags & pwdata[`BIT_PC_HIGH])) begin
            pcHighFlag_q <= 1'b0;
         end
      end
   end

   // global enable is the core's one switch, so it gates every source
   always_comb begin
      pending     = '0;
      pending[2]  = globalEn_q & enable_q[2] & (extFlag_q | levelAct); // R16
      pending[3]  = globalEn_q & enable_q[0] & pcLowFlag_q;
      pending[4]  = globalEn_q & enable_q[1] & pcHighFlag_q;
      pending[`NUM_SRC:5] = otherIrq & {13{globalEn_q}}; // R3 R4
   end
   // level wake is asynchronous in silicon; a released level wakes only
   assign wakeReq = levelAct | pcLowEvent | pcHighEvent; // R9 R13 R14

   // index i maps to address i-1; vector zero is the reset fetch
   always_comb begin
      req_d.take   = |pending;
      req_d.vector = (|pending) ? lowestVec(pending) - 5'h01
                                : `VEC_RESET; // R1 R2 R19
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         vecReq   <= '0; // R1
         ackVec_q <= `VEC_RESET;
         state_q  <= ext_irq_pkg::VEC_IDLE;
      end else begin
         unique case (state_q)
            ext_irq_pkg::VEC_IDLE: begin
               vecReq   <= req_d;
               ackVec_q <= req_d.vector;
               if (req_d.take) begin
                  state_q <= ext_irq_pkg::VEC_ACK;
               end
            end
            ext_irq_pkg::VEC_ACK: begin
               if (vecAck) begin
                  vecReq  <= '0;
                  state_q <= ext_irq_pkg::VEC_IDLE;
               end
            end
         endcase
      end
   end

   // a level released before it is latched wakes the part but leaves no
   // request behind; once latched it stands until the core acknowledges
   chk_level_req_held: assert property ( // R11
      levelAct & globalEn_q & enable_q[2] &
      (state_q == ext_irq_pkg::VEC_IDLE) |=> vecReq.take)
      else $error("level request not taken while pin low");
   chk_flag_set_edge: assert property ( // R17
      extEvent & (sense != ext_irq_pkg::SENSE_LOW) |=> extFlag_q)
      else $error("ext flag not set on edge");
   chk_level_flag_clr: assert property ( // R17
      sense == ext_irq_pkg::SENSE_LOW |=> !extFlag_q)
      else $error("ext flag set in level mode");
   chk_flag_ack_clr: assert property ( // R17
      (ackExt | (wrFlags & pwdata[`BIT_EXT])) & !extEvent |=> !extFlag_q)
      else $error("ext flag not cleared by ack or write");
   chk_any_change: assert property ( // R15
      (sense == ext_irq_pkg::SENSE_ANY) & ioClkRun &
      (extSync2_q != extPrev_q) |=> extFlag_q)
      else $error("ext flag missed a change in toggle mode");
   chk_low_group_set: assert property ( // R6
      $changed(pcSync2_q[7:0] & maskLow_q) && $stable(maskLow_q)
      |=> pcLowFlag_q)
      else $error("low group toggle missed");
   chk_high_group_set: assert property ( // R7
      $changed(pcSync2_q[11:8] & maskHigh_q) && $stable(maskHigh_q)
      |=> pcHighFlag_q)
      else $error("high group toggle missed");
   chk_mask_ignore: assert property ( // R8
      !pcLowFlag_q && (maskLow_q == 8'h00) |=> !pcLowFlag_q)
      else $error("masked pin set low group flag");
   chk_no_edge_sleep: assert property ( // R12
      !ioClkRun && !extFlag_q && (sense != ext_irq_pkg::SENSE_LOW)
      |=> !extFlag_q)
      else $error("edge flagged without io clock");
   chk_enable_gate: assert property ( // R16
      !globalEn_q && (state_q == ext_irq_pkg::VEC_IDLE) |=> !vecReq.take)
      else $error("request taken without global enable");
   // ext has the lowest live index, so it wins over every other source
   sequence extTaken;
      state_q == ext_irq_pkg::VEC_IDLE ##0 pending[2] ##1 1'b1;
   endsequence
   chk_prio_ext: assert property ( // R2 R19
      extTaken |-> vecReq.take && vecReq.vector == `VEC_EXT)
      else $error("ext request not vectored first");
   chk_high_vec: assert property ( // R2
      state_q == ext_irq_pkg::VEC_IDLE && pending[4:2] == 3'b100
      |=> vecReq.vector == `VEC_PC_HIGH)
      else $error("high group vector wrong");
   chk_last_vec: assert property ( // R4
      state_q == ext_irq_pkg::VEC_IDLE && pending == {1'b1, 16'h0000}
      |=> vecReq.vector == `VEC_LAST)
      else $error("last source vector wrong");
   chk_req_hold: assert property ( // R19
      state_q == ext_irq_pkg::VEC_ACK && !vecAck |=> $stable(vecReq))
      else $error("taken vector changed before acknowledge");
endmodule // external_interrupt_vectoring
`default_nettype wire

// [bench/pin_stim_model.sv]
// board-side driver for the dedicated pin and the pin-change pins
`timescale 1ns/1ps
`default_nettype none
module pin_stim_model (
   input  wire logic        mclk,
   input  wire logic        extLow,
   input  wire logic [11:0] pcFlip,
   output logic             ext_irq_pin,
   output logic      [11:0] pin_change_inputs
);
   // levels change only on a clock edge and are held until told again,
   // so every pulse lasts at least one whole clock period
   initial begin
      ext_irq_pin = 1'b1;
      pin_change_inputs = 12'h000;
   end
   always @(posedge mclk) begin
      ext_irq_pin <= ~extLow;
      pin_change_inputs <= pin_change_inputs ^ pcFlip;
   end
endmodule // pin_stim_model
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the external interrupt and vectoring block
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_map.svh"
module tb;
   logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, pcFlip;
   logic [31:0] pwdata, prdata, rd;
   logic extLow, extPin, ioClkRun, vecAck, wakeReq;
   logic [11:0] pcPins;
   logic [12:0] otherIrq;
   ext_irq_pkg::vec_req_s vecReq;
   int miscompares = 0, checks = 0, cyc = 0;

   external_interrupt_vectoring u_external_interrupt_vectoring (
      .mclk(mclk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_irq_pin(extPin), .pin_change_inputs(pcPins),
      .ioClkRun(ioClkRun), .otherIrq(otherIrq), .vecAck(vecAck),
      .vecReq(vecReq), .wakeReq(wakeReq));
   pin_stim_model u_pin_stim_model (.mclk(mclk), .extLow(extLow),
      .pcFlip(pcFlip), .ext_irq_pin(extPin), .pin_change_inputs(pcPins));

   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         finish_test();
      end
   end

   task automatic check(input string n, input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      check("slverr", pslverr, a == 12'h7f0);
      psel <= 0; penable <= 0;
      @(posedge mclk);
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // waits up to 40 cycles for a taken vector and checks its number; ack is left to ack()
   task automatic take(input logic [4:0] v);
      int n = 0;
      while (vecReq.take !== 1'b1 && n < 40) begin
         @(posedge mclk);
         n++;
      end
      check("vector", {vecReq.take, vecReq.vector}, {1'b1, v});
   endtask
   task automatic ack();
      vecAck <= 1;
      @(posedge mclk);
      vecAck <= 0;
      cyc_n(2);
   endtask

   task automatic t_reset();
      check("reset vec", vecReq, 6'h00);
      apb(0, `ADDR_MCU_CTRL, 0);
      check("sense rst", rd[1:0], 2'b00);
      apb(0, 12'h7f0, 0);
      check("unmapped", rd, 0);
      apb(1, `ADDR_CORE_CTRL, 1);
      $display("test reset done");
   endtask
   task automatic t_pin_change();
      apb(1, `ADDR_PC_MASK_LOW, 32'h08);
      apb(1, `ADDR_PC_MASK_HIGH, 32'h02);
      apb(1, `ADDR_IRQ_ENABLE, 32'h30);
      pcFlip <= 12'h020; @(posedge mclk); pcFlip <= 0;
      cyc_n(10);
      check("masked", vecReq.take, 0);
      pcFlip <= 12'h008; @(posedge mclk); pcFlip <= 0;
      take(`VEC_PC_LOW);
      ack();
      pcFlip <= 12'h200; @(posedge mclk); pcFlip <= 0;
      take(`VEC_PC_HIGH);
      ack();
      $display("test pin change done");
   endtask
   task automatic t_edge();
      apb(1, `ADDR_MCU_CTRL, 32'h2);
      apb(1, `ADDR_IRQ_ENABLE, 32'h40);
      extLow <= 1;
      take(`VEC_EXT);
      apb(0, `ADDR_IRQ_FLAGS, 0);
      check("flag set", rd[`BIT_EXT], 1);
      ack();
      apb(0, `ADDR_IRQ_FLAGS, 0);
      check("flag ack", rd[`BIT_EXT], 0);
      extLow <= 0;
      cyc_n(8);
      check("no rise", vecReq.take, 0);
      apb(1, `ADDR_MCU_CTRL, 32'h1);
      extLow <= 1;
      take(`VEC_EXT);
      ack();
      extLow <= 0;
      take(`VEC_EXT);
      ack();
      $display("test edge done");
   endtask
   task automatic t_level();
      apb(1, `ADDR_MCU_CTRL, 32'h0);
      extLow <= 1;
      take(`VEC_EXT);
      check("wake", wakeReq, 1);
      apb(0, `ADDR_IRQ_FLAGS, 0);
      check("lvl flag", rd[`BIT_EXT], 0);
      extLow <= 0;
      cyc_n(4);
      ack();
      check("lvl gone", vecReq.take, 0);
      $display("test level done");
   endtask
   task automatic t_sleep();
      apb(1, `ADDR_MCU_CTRL, 32'h3);
      ioClkRun <= 0;
      extLow <= 1;
      cyc_n(4);
      extLow <= 0;
      cyc_n(10);
      check("sleep edge", vecReq.take, 0);
      ioClkRun <= 1;
      $display("test sleep done");
   endtask
   task automatic t_priority();
      apb(1, `ADDR_IRQ_ENABLE, 0);
      apb(1, `ADDR_CORE_CTRL, 0);
      otherIrq <= 13'h021;
      cyc_n(6);
      check("global off", vecReq.take, 0);
      apb(1, `ADDR_CORE_CTRL, 1);
      take(`VEC_WATCHDOG);
      otherIrq <= 13'h020;
      ack();
      take(5'h09);
      otherIrq <= 13'h1000;
      ack();
      take(`VEC_LAST);
      otherIrq <= 0;
      ack();
      $display("test priority done");
   endtask

   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      sys_rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; extLow = 0; pcFlip = 0; ioClkRun = 1;
      otherIrq = 0; vecAck = 0;
      cyc_n(12);
      sys_rst <= 0;
      @(posedge mclk);
      t_reset();
      t_pin_change();
      t_edge();
      t_level();
      t_sleep();
      t_priority();
      finish_test();
   end
endmodule // tb
`default_nettype wire
